// ### bench/pcr_core_model.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Core stand-in: ALU completions, register numbers and GIE pulses.
// -----------------------------------------------------------------------
module pcr_core_model
    import pcr_pkg::*;
(
    input wire logic aclk,
    output logic alu_done,
    output pcr_op_type alu_op,
    output logic [15:0] alu_a,
    output logic [15:0] alu_b,
    output logic [15:0] alu_result,
    output logic [3:0] reg_num,
    output logic gie_set,
    output logic gie_clear
);
    // Quiet values from time zero.
    initial begin
        {alu_done, gie_set, gie_clear, reg_num, alu_a, alu_b, alu_result} = '0;
        alu_op = PCR_OP_LOGIC;
    end
    // One instruction completes; operands are inverted after so stale data never passes.
    task automatic op(input pcr_op_type o, input logic [15:0] a, input logic [15:0] b);
        @(posedge aclk);
        alu_op <= o;
        alu_a <= a;
        alu_b <= b;
        alu_result <= (o == PCR_OP_ADD) ? a + b : (o == PCR_OP_SUB) ? a - b : a & b;
        alu_done <= 1'b1;
        @(posedge aclk);
        alu_done <= 1'b0;
        alu_a <= ~a;
        alu_b <= ~b;
    endtask
    // One-cycle enable or disable pulse.
    task automatic gie(input logic en);
        @(posedge aclk);
        gie_set <= en;
        gie_clear <= !en;
        @(posedge aclk);
        gie_set <= 1'b0;
        gie_clear <= 1'b0;
    endtask
    task automatic sel(input logic [3:0] n);
        @(posedge aclk);
        reg_num <= n;
    endtask
endmodule

// ### bench/pcr_regs_asserts.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Port checks for the control registers.
// -----------------------------------------------------------------------
module pcr_regs_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] reg_num,
    input wire logic [15:0] reg_ram_addr,
    input wire logic core_clk_en,
    input wire logic [3:0] core_divisor
);
    // One clock domain, so one default clocking and reset.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst;
        $rose(aresetn) |-> core_divisor == 4'hf && reg_ram_addr == 16'h0100;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    property p_addr;
        $past(aresetn) |-> reg_ram_addr[3:0] == {$past(reg_num[2:0]), 1'b0}
            && (reg_ram_addr[4] || !$past(reg_num[3]));
    endproperty
    a_addr: assert property (p_addr) else $error("bad ram address");
    property p_div;
        core_clk_en && core_divisor == 4'h2 && $past(core_divisor) == 4'h2
            |=> !core_clk_en [*2] ##1 core_clk_en;
    endproperty
    a_div: assert property (p_div) else $error("bad core enable period");
    property p_hi;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_wlat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write response late");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read data late");
endmodule
bind pcr_regs pcr_regs_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .reg_num, .reg_ram_addr,
    .core_clk_en, .core_divisor);

// ### bench/processor_control_registers_bench.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Register bank bench: bus sequences with expected values.
// -----------------------------------------------------------------------
module processor_control_registers_bench
    import pcr_pkg::*;
;
    typedef struct {pcr_op_type o; logic [15:0] a; logic [15:0] b; logic g; logic [4:0] f;}
        pcr_case_type;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0;
    logic [15:0] s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic alu_done, gie_set, gie_clear, core_clk_en;
    pcr_op_type alu_op;
    logic [15:0] alu_a, alu_b, alu_result, reg_ram_addr;
    logic [3:0] reg_num, core_divisor;
    logic [3:0] dv[3] = '{4'h0, 4'hf, 4'h2};
    pcr_case_type ops[7] = '{'{PCR_OP_ADD, 16'h7fff, 16'h1, 1'b0, 5'h0c},
        '{PCR_OP_ADD, 16'h8000, 16'h8000, 1'b0, 5'h07}, '{PCR_OP_SUB, 16'h0, 16'h1, 1'b0, 5'h0a},
        '{PCR_OP_SUB, 16'h8000, 16'h1, 1'b0, 5'h04},
        '{PCR_OP_LOGIC, 16'hffff, 16'h8000, 1'b1, 5'h18},
        '{PCR_OP_LOGIC, 16'h00ff, 16'h0f00, 1'b0, 5'h01}, '{PCR_OP_ADD, 16'h1, 16'h1, 1'b0, 5'h0}};
    int fails = 0, checks = 0, p;
    pcr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .alu_done, .alu_op, .alu_a, .alu_b, .alu_result, .reg_num, .gie_set,
        .gie_clear, .reg_ram_addr, .core_clk_en, .core_divisor);
    pcr_core_model core (.aclk, .alu_done, .alu_op, .alu_a, .alu_b, .alu_result, .reg_num,
        .gie_set, .gie_clear);
    always #10 aclk = ~aclk;
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Ready is raised only once the answer shows, so the slave must hold it a cycle.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({32'h0, s_axi_bresp}, {32'h0, er});
    endtask
    // Read data is ignored on an error response.
    task automatic rd(input logic [15:0] a, input logic [1:0] er, input logic [31:0] ed);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, (er != 2'h0) ? 32'h0 : s_axi_rdata}, {er, ed});
    endtask
    // Cycles from one core enable pulse to the next.
    task automatic period();
        @(posedge aclk);
        while (!core_clk_en) @(posedge aclk);
        p = 0;
        do begin
            @(posedge aclk);
            p++;
        end while (!core_clk_en);
    endtask
    task automatic final_report();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PCR_FLAGS_ADDR, PCR_RESP_OKAY, 32'h0);
        rd(PCR_BASE_ADDR, PCR_RESP_OKAY, 32'h0100);
        rd(PCR_DIV_ADDR, PCR_RESP_OKAY, 32'hf);
        rd(16'hc006, PCR_RESP_SLVERR, 32'h0);
        wr(16'hc00c, 32'h5, PCR_RESP_SLVERR);
        wr(PCR_FLAGS_ADDR, 32'hffff, PCR_RESP_OKAY);
        wr(PCR_REV_ADDR, 32'hffff, PCR_RESP_OKAY);
        rd(PCR_FLAGS_ADDR, PCR_RESP_OKAY, 32'h0);
        rd(PCR_REV_ADDR, PCR_RESP_OKAY, {16'h0, PCR_REV_DEFAULT});
        wr(PCR_BASE_ADDR, 32'hffff_abc0, PCR_RESP_OKAY);
        rd(PCR_BASE_ADDR, PCR_RESP_OKAY, 32'habc0);
        for (int i = 0; i < 16; i++) begin
            core.sel(i[3:0]);
            repeat (2) @(posedge aclk);
            chk(34'(reg_ram_addr), 34'(16'habc0 | {11'h0, i[3:0], 1'b0}));
        end
        foreach (dv[k]) begin
            wr(PCR_DIV_ADDR, {28'h0, dv[k]}, PCR_RESP_OKAY);
            rd(PCR_DIV_ADDR, PCR_RESP_OKAY, {28'h0, dv[k]});
            period();
            period();
            chk(34'(p), 34'(dv[k]) + 34'h1);
            chk(34'(core_divisor), 34'(dv[k]));
        end
        // The core is slowed now, yet address formation must still follow every system cycle.
        core.sel(4'h7);
        repeat (2) @(posedge aclk);
        chk(34'(reg_ram_addr), 34'h0abce);
        foreach (ops[k]) begin
            core.gie(ops[k].g);
            core.op(ops[k].o, ops[k].a, ops[k].b);
            rd(PCR_FLAGS_ADDR, PCR_RESP_OKAY, {27'h0, ops[k].f});
        end
        final_report();
    end
    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        final_report();
    end
endmodule

// ### src/pcr_core_enable.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Core clock enable: one pulse every divisor+1 system cycles.
// -----------------------------------------------------------------------
module pcr_core_enable
    import pcr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    pcr_div_if.gen div
);

    logic [PCR_DIV_W-1:0] count;
    logic [PCR_DIV_W-1:0] next_count;
    logic wrap;

    // Divisor is compared every cycle, so a change takes effect at once and can cut the current period short.
    assign wrap = (count >= div.divisor);
    assign next_count = wrap ? '0 : count + 4'h1;

    // Counter and enable pulse; only the core consumes this enable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            div.core_en <= 1'b0;
        end else begin
            count <= next_count;
            div.core_en <= wrap;
        end
    end

endmodule

// ### src/pcr_div_if.sv
`timescale 1ns/100ps
// Divisor setting toward the core clock enable generator.
interface pcr_div_if;
    logic [3:0] divisor;
    logic core_en;
    modport ctrl (output divisor, input core_en);
    modport gen (input divisor, output core_en);
endinterface

// ### src/pcr_pkg.sv
// Contract
// - Flags register read-only, upper bits zero
// - Bit 4 shows global interrupt enable
// - Bit 3 is result sign bit
// - Bit 2 signals add/subtract overflow
// - Bit 1 signals carry or borrow
// - Bit 0 set on zero result
// - Window base register resets to 0x0100
// - Register address is base OR number<<1
// - Base field bits 15:4 read/write
// - Read-only fixed revision register
// - Divisor low four bits, reset ones
// - Divisor slows only the core clock
// - Core rate is system rate over N+1
package pcr_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [15:0] PCR_FLAGS_ADDR = 16'hc000;
    localparam logic [15:0] PCR_BASE_ADDR = 16'hc002;
    localparam logic [15:0] PCR_REV_ADDR = 16'hc004;
    localparam logic [15:0] PCR_DIV_ADDR = 16'hc008;
    localparam int PCR_ADDR_W = 16;

    // -------------------------------------------------------------------
    // Fields and reset values
    // -------------------------------------------------------------------
    localparam int PCR_FLAG_W = 5;
    localparam int PCR_GIE_BIT = 4;
    localparam int PCR_NEG_BIT = 3;
    localparam int PCR_OVF_BIT = 2;
    localparam int PCR_CRY_BIT = 1;
    localparam int PCR_ZER_BIT = 0;
    localparam int PCR_BASE_LSB = 4;
    localparam int PCR_BASE_W = 12;
    localparam logic [15:0] PCR_BASE_RESET = 16'h0100;
    localparam int PCR_DIV_W = 4;
    localparam logic [3:0] PCR_DIV_RESET = 4'hf;
    // Revision value is arbitrary.
    localparam logic [15:0] PCR_REV_DEFAULT = 16'h0a01;
    localparam logic [1:0] PCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCR_RESP_SLVERR = 2'h2;

    // ALU operation classes that decide how overflow and carry are formed.
    typedef enum logic [1:0] {
        PCR_OP_ADD,
        PCR_OP_SUB,
        PCR_OP_LOGIC
    } pcr_op_type;

endpackage

// ### src/pcr_regs.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Processor control registers behind an AXI4-Lite slave.
// -----------------------------------------------------------------------
module pcr_regs
    import pcr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic alu_done,
    input wire pcr_op_type alu_op,
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    input wire logic [15:0] alu_result,
    input wire logic [3:0] reg_num,
    input wire logic gie_set,
    input wire logic gie_clear,
    output logic [15:0] reg_ram_addr,
    output logic core_clk_en,
    output logic [3:0] core_divisor
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [PCR_FLAG_W-1:0] flags;
    logic [PCR_BASE_W-1:0] base;
    logic [PCR_DIV_W-1:0] divisor;
    logic aw_held;
    logic w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    pcr_div_if div_bus ();

    // -------------------------------------------------------------------
    // Flag computation from the completing ALU operation
    // -------------------------------------------------------------------
    logic [16:0] sum_ext;
    logic [16:0] dif_ext;
    logic add_ovf;
    logic sub_ovf;
    logic next_ovf;
    logic next_cry;
    logic next_neg;
    logic next_zer;

    assign sum_ext = {1'b0, alu_a} + {1'b0, alu_b};
    assign dif_ext = {1'b0, alu_a} - {1'b0, alu_b};
    // Signed overflow: operands alike in sign, result differs (add), or unlike (sub).
    assign add_ovf = (alu_a[15] == alu_b[15]) && (alu_result[15] != alu_a[15]);
    assign sub_ovf = (alu_a[15] != alu_b[15]) && (alu_result[15] != alu_a[15]);
    assign next_ovf = (alu_op == PCR_OP_ADD) ? add_ovf :
                      (alu_op == PCR_OP_SUB) ? sub_ovf : 1'b0;
    assign next_cry = (alu_op == PCR_OP_ADD) ? sum_ext[16] :
                      (alu_op == PCR_OP_SUB) ? dif_ext[16] : 1'b0;
    assign next_neg = alu_result[15];
    assign next_zer = (alu_result == 16'h0000);

    // Arithmetic flags update at instruction completion; set of GIE wins over clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= '0;
        end else begin
            if (alu_done) begin
                flags[PCR_NEG_BIT] <= next_neg;
                flags[PCR_OVF_BIT] <= next_ovf;
                flags[PCR_CRY_BIT] <= next_cry;
                flags[PCR_ZER_BIT] <= next_zer;
            end
            if (gie_set) begin
                flags[PCR_GIE_BIT] <= 1'b1;
            end else if (gie_clear) begin
                flags[PCR_GIE_BIT] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // General register address formation
    // -------------------------------------------------------------------
    logic [15:0] next_ram_addr;
    // Low bits of the base are reserved; software keeps them zero, hardware
    // does not store them, but base bit 4 overlaps the index top bit, so the OR can merge them.
    assign next_ram_addr = ({base, 4'h0} | {11'h000, reg_num, 1'b0}) & 16'hfffe;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ram_addr <= PCR_BASE_RESET;
        end else begin
            reg_ram_addr <= next_ram_addr;
        end
    end

    // -------------------------------------------------------------------
    // Write channel: address and data accepted in either order
    // -------------------------------------------------------------------
    logic do_write;
    logic wr_hit_base;
    logic wr_hit_div;
    logic wr_hit_ro;
    logic wr_ok;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit_base = (aw_addr == PCR_BASE_ADDR);
    assign wr_hit_div = (aw_addr == PCR_DIV_ADDR);
    // Read-only registers accept writes silently so firmware sees no fault.
    assign wr_hit_ro = (aw_addr == PCR_FLAGS_ADDR) || (aw_addr == PCR_REV_ADDR);
    assign wr_ok = wr_hit_base || wr_hit_div || wr_hit_ro;

    // Channel holders and response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Ready only while the slot is empty, so one write is in flight at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // -------------------------------------------------------------------
    // Writable registers
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base <= PCR_BASE_RESET[15:PCR_BASE_LSB];
            divisor <= PCR_DIV_RESET;
        end else if (do_write) begin
            if (wr_hit_base) begin
                if (w_strb[0]) begin
                    base[3:0] <= w_data[7:4];
                end
                if (w_strb[1]) begin
                    base[11:4] <= w_data[15:8];
                end
            end
            if (wr_hit_div && w_strb[0]) begin
                divisor <= w_data[PCR_DIV_W-1:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    logic [15:0] rd_word;
    logic rd_ok;

    assign rd_ok = (s_axi_araddr == PCR_FLAGS_ADDR) || (s_axi_araddr == PCR_BASE_ADDR) ||
                   (s_axi_araddr == PCR_REV_ADDR) || (s_axi_araddr == PCR_DIV_ADDR);
    assign rd_word = (s_axi_araddr == PCR_FLAGS_ADDR) ? {11'h000, flags} :
                     (s_axi_araddr == PCR_BASE_ADDR) ? {base, 4'h0} :
                     (s_axi_araddr == PCR_REV_ADDR) ? PCR_REV_DEFAULT :
                     (s_axi_araddr == PCR_DIV_ADDR) ? {12'h000, divisor} : 16'h0000;

    // Address taken one cycle after valid; data registered with it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PCR_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rd_word};
                s_axi_rresp <= rd_ok ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Core clock enable; peripherals keep running on aclk itself
    // -------------------------------------------------------------------
    assign div_bus.divisor = divisor;

    pcr_core_enable u_core_enable (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(div_bus)
    );

    // Enable and divisor copies registered for the outputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_en <= 1'b0;
            core_divisor <= PCR_DIV_RESET;
        end else begin
            core_clk_en <= div_bus.core_en;
            core_divisor <= divisor;
        end
    end

endmodule
